//--- shared/nsf_pkg.sv
// Package of offsets, reset values and flag positions for the nibble register file.
`default_nettype none
package nsf_pkg;
  // Register addresses.
  localparam logic [3:0] ADR_PORT_ZERO   = 4'h0;
  localparam logic [3:0] ADR_PORT_FOUR   = 4'h1;
  localparam logic [3:0] ADR_PTR_LOW     = 4'h2;
  localparam logic [3:0] ADR_PTR_HIGH    = 4'h3;
  localparam logic [3:0] ADR_PORT_ONE    = 4'h4;
  localparam logic [3:0] ADR_IR_CTRL     = 4'h5;
  localparam logic [3:0] ADR_STK_LOW     = 4'h6;
  localparam logic [3:0] ADR_STK_HIGH    = 4'h7;
  localparam logic [3:0] ADR_PORT_TWO    = 4'h8;
  localparam logic [3:0] ADR_SELFPROG    = 4'h9;
  localparam logic [3:0] ADR_SCRATCH_LO  = 4'hA;
  localparam logic [3:0] ADR_SCRATCH_HI  = 4'hB;
  localparam logic [3:0] ADR_PORT_THREE  = 4'hC;
  localparam logic [3:0] ADR_CLOCK_SETUP = 4'hD;
  localparam logic [3:0] ADR_PIN_SETUP   = 4'hE;
  localparam logic [3:0] ADR_UV_SETUP    = 4'hF;
  // Reset values.
  localparam logic [3:0] RST_PORT        = 4'hF;
  localparam logic [3:0] RST_ZERO        = 4'h0;
  localparam logic [1:0] RST_PTR_HIGH    = 2'h0;
  localparam logic [3:0] RST_STK_LOW     = 4'hF;
  localparam logic [1:0] RST_STK_HIGH    = 2'h1;
  localparam logic [3:0] RST_UV_POR      = 4'h8;
  localparam logic [15:0] RST_FLAGS      = 16'h23FF;
  // Field positions.
  localparam int PIN_SETUP_PUSHPULL_BIT  = 1;
  localparam int UV_UNDEF_BIT            = 2;
  // Flag positions in the function flag array.
  localparam logic [3:0] FLG_STOP        = 4'hF;
  localparam logic [3:0] FLG_SLEEP       = 4'hE;
  localparam logic [3:0] FLG_WDOG_RUN    = 4'hD;
  localparam logic [3:0] FLG_WDOG_CLEAR  = 4'hC;
  localparam logic [3:0] FLG_MAP_UPPER   = 4'hB;
  localparam logic [3:0] FLG_MAP_LOWER   = 4'hA;
  // Address spans.
  localparam int DATA_MEM_DEPTH          = 64;
  localparam logic [9:0] PROG_ADDR_LAST  = 10'h3FF;
endpackage : nsf_pkg
`default_nettype wire

//--- src/nsf_register_file.sv
// Nibble special register file, function flag array and indirect data memory.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// (RULE_01) Sixteen registers, 4-bit direct address, four rows.
// (RULE_02) Sixteen flags, position chosen by pointer low.
// (RULE_03) Data memory of 64 bit-addressable nibbles.
// (RULE_04) Program space is 000H to 3FFH, unpaged.
// (RULE_05) Port latches reset to all ones always.
// (RULE_06) Data pointer clears; high half two bits.
// (RULE_07) Stack pointer resets to 1111 and 01.
// (RULE_08) Self-program control gated by map flags; resets zero.
// (RULE_09) Clock setup cleared only by power-on.
// (RULE_10) Pin setup: other resets clear bit 1 only.
// (RULE_11) Undervoltage setup 1x00 on power-on; else kept.
// (RULE_12) Infrared output control resets to zero.
// (RULE_13) Scratch nibbles reset zero, store written values.
// (RULE_14) Unimplemented bits read as zero.
// (RULE_15) Reduced variants must not write absent registers.
// (RULE_16) Low level on port zero/one leaves stop.
// (RULE_17) Port two selectable open-drain or push-pull.
// (RULE_18) Ports two, three, four-high bitwise set/clear.
// (RULE_19) Flags write-only, set/clear at pointer position.
// (RULE_20) Port writes hit latch; port reads return pins.
// (RULE_21) Changes happen only at final cycle state, except the pin wake that clears stop.
// (RULE_22) Writes on clock edge; register reads combinational, memory read registered.
// (RULE_23) Gated self-program writes ignored, reads zero.
module nsf_register_file #(
  parameter int DATA_DEPTH = nsf_pkg::DATA_MEM_DEPTH
) (
  // Clock and resets.
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_por,
  // Cycle timing from the core.
  input  wire logic        i_final_cycle_state,
  // Register port.
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic [3:0]  i_reg_wdata,
  output logic      [3:0]  o_reg_rdata,
  // Function flag operations.
  input  wire logic        i_flag_set,
  input  wire logic        i_flag_clr,
  // Indirect data memory port.
  input  wire logic [5:0]  i_mem_addr,
  input  wire logic        i_mem_wr,
  input  wire logic [3:0]  i_mem_wdata,
  input  wire logic        i_mem_bit_set,
  input  wire logic        i_mem_bit_clr,
  input  wire logic [1:0]  i_mem_bit_sel,
  output logic      [3:0]  o_mem_rdata,
  // Program address check.
  input  wire logic [9:0]  i_prog_addr,
  output logic             o_prog_addr_ok,
  // Pins: one open-drain or push-pull group per port.
  input  wire logic [3:0]  i_port_zero_pin,
  input  wire logic [3:0]  i_port_one_pin,
  input  wire logic [3:0]  i_port_two_pin,
  input  wire logic [3:0]  i_port_three_pin,
  input  wire logic [3:0]  i_port_four_pin,
  output logic      [3:0]  o_port_zero_out,
  output logic      [3:0]  o_port_zero_oe,
  output logic      [3:0]  o_port_one_out,
  output logic      [3:0]  o_port_one_oe,
  output logic      [3:0]  o_port_two_out,
  output logic      [3:0]  o_port_two_oe,
  output logic      [3:0]  o_port_three_out,
  output logic      [3:0]  o_port_three_oe,
  output logic      [3:0]  o_port_four_out,
  output logic      [3:0]  o_port_four_oe,
  // Register contents for the rest of the chip.
  output logic      [5:0]  o_data_pointer,
  output logic      [5:0]  o_stack_ptr,
  output logic      [3:0]  o_ir_output_control,
  output logic      [3:0]  o_selfprog_control,
  output logic      [3:0]  o_clock_setup,
  output logic      [3:0]  o_pin_setup,
  output logic      [3:0]  o_undervoltage_setup,
  output logic      [15:0] o_function_flags,
  output logic             o_stop_wake
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage.
  logic [3:0]  port_latch_ff [5];
  logic [3:0]  ptr_low_ff;
  logic [1:0]  ptr_high_ff;
  logic [3:0]  stk_low_ff;
  logic [1:0]  stk_high_ff;
  logic [3:0]  ir_ctrl_ff;
  logic [3:0]  selfprog_ff;
  logic [3:0]  scratch_lo_ff;
  logic [3:0]  scratch_hi_ff;
  logic [3:0]  clock_setup_ff;
  logic [3:0]  pin_setup_ff;
  logic [3:0]  uv_setup_ff;
  logic [15:0] flags_ff;
  logic [3:0]  data_mem [DATA_DEPTH];
  logic        commit;
  logic        map_ok;
  logic [3:0]  port_pins [5];

  // Index of a port latch for an address, or 7 when the address is no port.
  function automatic logic [2:0] port_index(input logic [3:0] adr);
    case (adr)
      nsf_pkg::ADR_PORT_ZERO:  port_index = 3'h0;
      nsf_pkg::ADR_PORT_ONE:   port_index = 3'h1;
      nsf_pkg::ADR_PORT_TWO:   port_index = 3'h2;
      nsf_pkg::ADR_PORT_THREE: port_index = 3'h3;
      nsf_pkg::ADR_PORT_FOUR:  port_index = 3'h4;
      default:                 port_index = 3'h7;
    endcase
  endfunction : port_index

  // Writes from one instruction land together at its last state.
  assign commit = i_final_cycle_state;                                       // [RULE_21]
  assign map_ok = flags_ff[nsf_pkg::FLG_MAP_UPPER] & ~flags_ff[nsf_pkg::FLG_MAP_LOWER]; // [RULE_08]

  assign port_pins[0] = i_port_zero_pin;
  assign port_pins[1] = i_port_one_pin;
  assign port_pins[2] = i_port_two_pin;
  assign port_pins[3] = i_port_three_pin;
  assign port_pins[4] = i_port_four_pin;

  ////////////////////////////////////////////////////////////////////////////
  // Port latches, with bitwise set and clear through the flag array.
  genvar gp;
  generate
    for (gp = 0; gp < 5; gp++) begin : g_port
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          port_latch_ff[gp] <= nsf_pkg::RST_PORT;                            // [RULE_05]
        end else if (commit && i_reg_wr && port_index(i_reg_addr) == 3'(gp)) begin
          port_latch_ff[gp] <= i_reg_wdata;                                  // [RULE_20] [RULE_22]
        end else if (commit && (i_flag_set ^ i_flag_clr)) begin
          // Only the addressed bit moves; neighbours keep their value.
          if (gp == 2 && ptr_low_ff[3:2] == 2'h0) begin
            port_latch_ff[gp][ptr_low_ff[1:0]] <= i_flag_set;                // [RULE_18]
          end else if (gp == 3 && ptr_low_ff[3:2] == 2'h1) begin
            port_latch_ff[gp][ptr_low_ff[1:0]] <= i_flag_set;                // [RULE_18]
          end else if (gp == 4 && ptr_low_ff == 4'h8) begin
            port_latch_ff[gp][3] <= i_flag_set;                              // [RULE_18]
          end else if (gp == 4 && ptr_low_ff == 4'h9) begin
            port_latch_ff[gp][2] <= i_flag_set;                              // [RULE_18]
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pointers, control and scratch registers.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ptr_low_ff  <= nsf_pkg::RST_ZERO;                                      // [RULE_06]
      ptr_high_ff <= nsf_pkg::RST_PTR_HIGH;                                  // [RULE_06]
    end else if (commit && i_reg_wr && i_reg_addr == nsf_pkg::ADR_PTR_LOW) begin
      ptr_low_ff <= i_reg_wdata;                                             // [RULE_22]
    end else if (commit && i_reg_wr && i_reg_addr == nsf_pkg::ADR_PTR_HIGH) begin
      ptr_high_ff <= i_reg_wdata[1:0];                                       // [RULE_06]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      stk_low_ff  <= nsf_pkg::RST_STK_LOW;                                   // [RULE_07]
      stk_high_ff <= nsf_pkg::RST_STK_HIGH;                                  // [RULE_07]
    end else if (commit && i_reg_wr && i_reg_addr == nsf_pkg::ADR_STK_LOW) begin
      stk_low_ff <= i_reg_wdata;
    end else if (commit && i_reg_wr && i_reg_addr == nsf_pkg::ADR_STK_HIGH) begin
      stk_high_ff <= i_reg_wdata[1:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ir_ctrl_ff    <= nsf_pkg::RST_ZERO;                                    // [RULE_12]
      selfprog_ff   <= nsf_pkg::RST_ZERO;                                    // [RULE_08]
      scratch_lo_ff <= nsf_pkg::RST_ZERO;                                    // [RULE_13]
      scratch_hi_ff <= nsf_pkg::RST_ZERO;                                    // [RULE_13]
    end else if (commit && i_reg_wr) begin
      if (i_reg_addr == nsf_pkg::ADR_IR_CTRL) begin
        ir_ctrl_ff <= i_reg_wdata;
      end
      if (i_reg_addr == nsf_pkg::ADR_SELFPROG && map_ok) begin
        selfprog_ff <= i_reg_wdata;                                          // [RULE_23]
      end
      if (i_reg_addr == nsf_pkg::ADR_SCRATCH_LO) begin
        scratch_lo_ff <= i_reg_wdata;                                        // [RULE_13]
      end
      if (i_reg_addr == nsf_pkg::ADR_SCRATCH_HI) begin
        scratch_hi_ff <= i_reg_wdata;                                        // [RULE_13]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration: survives non-power-on resets as far as specified.
  always_ff @(posedge i_mclk) begin
    if (i_por) begin
      clock_setup_ff <= nsf_pkg::RST_ZERO;                                   // [RULE_09]
      pin_setup_ff   <= nsf_pkg::RST_ZERO;                                   // [RULE_10]
      uv_setup_ff    <= nsf_pkg::RST_UV_POR;                                 // [RULE_11]
    end else if (i_rst) begin
      // Clock and undervoltage setup hold; only the push-pull bit drops.
      pin_setup_ff[nsf_pkg::PIN_SETUP_PUSHPULL_BIT] <= 1'b0;                 // [RULE_10]
    end else if (commit && i_reg_wr) begin
      if (i_reg_addr == nsf_pkg::ADR_CLOCK_SETUP) begin
        clock_setup_ff <= i_reg_wdata;
      end
      if (i_reg_addr == nsf_pkg::ADR_PIN_SETUP) begin
        pin_setup_ff <= i_reg_wdata;
      end
      if (i_reg_addr == nsf_pkg::ADR_UV_SETUP) begin
        uv_setup_ff <= i_reg_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Function flag array.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      flags_ff <= nsf_pkg::RST_FLAGS;
    end else if (commit && (i_flag_set ^ i_flag_clr)) begin
      // The port-bit flags follow latches through flag operations only, not register writes; they are kept for completeness.
      flags_ff[ptr_low_ff] <= i_flag_set;                                    // [RULE_02] [RULE_19]
      // Stop may not be entered while any wake pin is already low.
      if (ptr_low_ff == nsf_pkg::FLG_STOP && i_flag_set && o_stop_wake) begin
        flags_ff[nsf_pkg::FLG_STOP] <= 1'b0;
      end
      if (ptr_low_ff == nsf_pkg::FLG_WDOG_RUN && !map_ok) begin
        flags_ff[nsf_pkg::FLG_WDOG_RUN] <= flags_ff[nsf_pkg::FLG_WDOG_RUN];
      end
      if (ptr_low_ff == nsf_pkg::FLG_SLEEP && i_flag_set) begin
        flags_ff[nsf_pkg::FLG_WDOG_RUN] <= 1'b1;
      end
    end else if (flags_ff[nsf_pkg::FLG_STOP] && o_stop_wake) begin
      flags_ff[nsf_pkg::FLG_STOP] <= 1'b0;                                   // [RULE_16]
    end else if (commit && i_reg_wr && i_reg_addr == nsf_pkg::ADR_SELFPROG && map_ok) begin
      flags_ff[nsf_pkg::FLG_WDOG_RUN] <= 1'b1;
    end
  end

  assign o_stop_wake = ~(&i_port_zero_pin) | ~(&i_port_one_pin);             // [RULE_16]

  ////////////////////////////////////////////////////////////////////////////
  // Indirect data memory, with single-bit set and clear.
  always_ff @(posedge i_mclk) begin
    if (commit && i_mem_wr) begin
      data_mem[i_mem_addr] <= i_mem_wdata;                                   // [RULE_03]
    end else if (commit && (i_mem_bit_set ^ i_mem_bit_clr)) begin
      data_mem[i_mem_addr][i_mem_bit_sel] <= i_mem_bit_set;                  // [RULE_03]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_mem_rdata <= 4'h0;
    end else begin
      o_mem_rdata <= data_mem[i_mem_addr];
    end
  end

  assign o_prog_addr_ok = (i_prog_addr <= nsf_pkg::PROG_ADDR_LAST);          // [RULE_04]

  ////////////////////////////////////////////////////////////////////////////
  // Read selection: port addresses return pin levels.
  always_comb begin
    o_reg_rdata = 4'h0;
    case (i_reg_addr)                                                        // [RULE_01] [RULE_22]
      nsf_pkg::ADR_PORT_ZERO:   o_reg_rdata = port_pins[0];                  // [RULE_20]
      nsf_pkg::ADR_PORT_ONE:    o_reg_rdata = port_pins[1];
      nsf_pkg::ADR_PORT_TWO:    o_reg_rdata = port_pins[2];
      nsf_pkg::ADR_PORT_THREE:  o_reg_rdata = port_pins[3];
      nsf_pkg::ADR_PORT_FOUR:   o_reg_rdata = port_pins[4];
      nsf_pkg::ADR_PTR_LOW:     o_reg_rdata = ptr_low_ff;
      nsf_pkg::ADR_PTR_HIGH:    o_reg_rdata = {2'h0, ptr_high_ff};           // [RULE_14]
      nsf_pkg::ADR_STK_LOW:     o_reg_rdata = stk_low_ff;
      nsf_pkg::ADR_STK_HIGH:    o_reg_rdata = {2'h0, stk_high_ff};           // [RULE_14]
      nsf_pkg::ADR_IR_CTRL:     o_reg_rdata = ir_ctrl_ff;
      nsf_pkg::ADR_SELFPROG:    o_reg_rdata = map_ok ? selfprog_ff : 4'h0;   // [RULE_23]
      nsf_pkg::ADR_SCRATCH_LO:  o_reg_rdata = scratch_lo_ff;
      nsf_pkg::ADR_SCRATCH_HI:  o_reg_rdata = scratch_hi_ff;
      nsf_pkg::ADR_CLOCK_SETUP: o_reg_rdata = clock_setup_ff;
      nsf_pkg::ADR_PIN_SETUP:   o_reg_rdata = pin_setup_ff;
      nsf_pkg::ADR_UV_SETUP:    o_reg_rdata = uv_setup_ff;
      default:                  o_reg_rdata = 4'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive: open drain pulls low only; port two may drive both levels.
  assign o_port_zero_out  = 4'h0;
  assign o_port_zero_oe   = ~port_latch_ff[0];
  assign o_port_one_out   = 4'h0;
  assign o_port_one_oe    = ~port_latch_ff[1];
  assign o_port_two_out   = pin_setup_ff[nsf_pkg::PIN_SETUP_PUSHPULL_BIT] ? port_latch_ff[2] : 4'h0;
  assign o_port_two_oe    = pin_setup_ff[nsf_pkg::PIN_SETUP_PUSHPULL_BIT] ? 4'hF : ~port_latch_ff[2]; // [RULE_17]
  assign o_port_three_out = 4'h0;
  assign o_port_three_oe  = ~port_latch_ff[3];
  assign o_port_four_out  = 4'h0;
  assign o_port_four_oe   = ~port_latch_ff[4];

  assign o_data_pointer       = {ptr_high_ff, ptr_low_ff};
  assign o_stack_ptr          = {stk_high_ff, stk_low_ff};
  assign o_ir_output_control  = ir_ctrl_ff;
  assign o_selfprog_control   = selfprog_ff;
  assign o_clock_setup        = clock_setup_ff;
  assign o_pin_setup          = pin_setup_ff;
  assign o_undervoltage_setup = uv_setup_ff;
  assign o_function_flags     = flags_ff;

endmodule : nsf_register_file
`default_nettype wire

//--- dv/nsf_reg_chk_sva.sv
// Assertion checker for the nibble register file.
`timescale 1ns/100ps
`default_nettype none
module nsf_reg_chk (
  // Clock and resets.
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_por,
  // Requests and pins.
  input  wire logic        i_final_cycle_state,
  input  wire logic [3:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic [3:0]  i_reg_wdata,
  input  wire logic        i_flag_set,
  input  wire logic        i_flag_clr,
  input  wire logic [3:0]  i_port_zero_pin,
  input  wire logic [3:0]  i_port_one_pin,
  // Observed state.
  input  wire logic [3:0]  o_reg_rdata,
  input  wire logic [3:0]  o_port_two_oe,
  input  wire logic [5:0]  o_data_pointer,
  input  wire logic [5:0]  o_stack_ptr,
  input  wire logic [3:0]  o_selfprog_control,
  input  wire logic [3:0]  o_clock_setup,
  input  wire logic [3:0]  o_pin_setup,
  input  wire logic [3:0]  o_undervoltage_setup,
  input  wire logic [15:0] o_function_flags,
  input  wire logic        o_stop_wake
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  logic gate;
  assign gate = o_function_flags[11] & ~o_function_flags[10];
  ////////////////////////////////////////////////////////////////////////////
  AST_PTR_RST: assert property ($fell(i_rst) |-> o_data_pointer == 6'h00 && o_stack_ptr == 6'h1F)
    else $error("pointer reset value wrong");
  AST_CFG_POR: assert property ($fell(i_rst) && $past(i_por) |-> o_clock_setup == 4'h0 && o_pin_setup == 4'h0
    && (o_undervoltage_setup & 4'hB) == 4'h8) else $error("power-on setup value wrong");
  // Depth three assumes a two-cycle reset after an idle cycle, as the bench applies it.
  AST_CFG_KEEP: assert property ($fell(i_rst) && !$past(i_por) |-> o_clock_setup == $past(o_clock_setup, 3)
    && o_pin_setup == ($past(o_pin_setup, 3) & 4'hD)) else $error("setup not kept over reset");
  AST_NO_COMMIT: assert property (!i_final_cycle_state |=> $stable(o_data_pointer) && $stable(o_stack_ptr)
    && $stable(o_function_flags[14:0])) else $error("state changed outside commit");
  AST_PTR_WRITE: assert property (i_final_cycle_state && i_reg_wr && i_reg_addr == 4'h2
    |=> o_data_pointer[3:0] == $past(i_reg_wdata)) else $error("pointer write lost");
  AST_SP_GATE: assert property (i_final_cycle_state && i_reg_wr && i_reg_addr == 4'h9 && !gate
    |=> $stable(o_selfprog_control)) else $error("gated self-program write taken");
  AST_SP_READ: assert property (i_reg_addr == 4'h9 && !gate |-> o_reg_rdata == 4'h0)
    else $error("gated self-program read not zero");
  AST_PORT_READ: assert property (i_reg_addr == 4'h0 |-> o_reg_rdata == i_port_zero_pin)
    else $error("port read not pin level");
  AST_UNIMPL: assert property (i_reg_addr == 4'h3 |-> o_reg_rdata[3:2] == 2'b00)
    else $error("unimplemented bits not zero");
  AST_FLAG_SET: assert property (i_final_cycle_state && i_flag_set && !i_flag_clr && o_data_pointer[3:0] < 4'hC
    |=> o_function_flags[$past(o_data_pointer[3:0])]) else $error("flag set missed");
  AST_WAKE: assert property (o_stop_wake == !(&i_port_zero_pin && &i_port_one_pin))
    else $error("stop wake wrong");
  AST_PUSHPULL: assert property (o_pin_setup[1] |-> o_port_two_oe == 4'hF)
    else $error("push-pull enable wrong");
endmodule : nsf_reg_chk
`default_nettype wire

//--- dv/testbench.sv
// Self-checking testbench for the nibble register file.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct { logic [3:0] adr; logic [3:0] wd; logic [3:0] rd; } nsf_row_type;
  logic        i_mclk, i_rst, i_por, i_final_cycle_state, i_reg_wr, i_flag_set, i_flag_clr;
  logic        i_mem_wr, i_mem_bit_set, i_mem_bit_clr, o_prog_addr_ok, o_stop_wake;
  logic [3:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, i_mem_wdata, o_mem_rdata;
  logic [3:0]  o_ir_output_control, o_selfprog_control, o_clock_setup, o_pin_setup, o_undervoltage_setup;
  logic [5:0]  i_mem_addr, o_data_pointer, o_stack_ptr;
  logic [1:0]  i_mem_bit_sel;
  logic [9:0]  i_prog_addr;
  logic [15:0] o_function_flags;
  logic [3:0]  p_pin [5];
  logic [3:0]  p_out [5];
  logic [3:0]  p_oe [5];
  int          bad_count, check_count;
  nsf_row_type rows [15] = '{'{4'h2, 4'h5, 4'h5}, '{4'h3, 4'hF, 4'h3}, '{4'h6, 4'hA, 4'hA}, '{4'h7, 4'hE, 4'h2},
    '{4'h5, 4'h9, 4'h9}, '{4'hA, 4'h6, 4'h6}, '{4'hB, 4'hC, 4'hC}, '{4'hD, 4'h7, 4'h7}, '{4'hF, 4'hB, 4'hB},
    '{4'h9, 4'h3, 4'h0}, '{4'h0, 4'h2, 4'hF}, '{4'hC, 4'hA, 4'h9}, '{4'h1, 4'h4, 4'h3}, '{4'h8, 4'h6, 4'h5},
    '{4'hE, 4'hA, 4'hA}};
  logic [3:0]  rst_rd [13] = '{4'hF, 4'h3, 4'h0, 4'h0, 4'hF, 4'h0, 4'hF, 4'h1, 4'h5, 4'h0, 4'h0, 4'h0, 4'h9};
  nsf_register_file nsf_register_file_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_por(i_por),
    .i_final_cycle_state(i_final_cycle_state), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_flag_set(i_flag_set), .i_flag_clr(i_flag_clr),
    .i_mem_addr(i_mem_addr), .i_mem_wr(i_mem_wr), .i_mem_wdata(i_mem_wdata), .i_mem_bit_set(i_mem_bit_set),
    .i_mem_bit_clr(i_mem_bit_clr), .i_mem_bit_sel(i_mem_bit_sel), .o_mem_rdata(o_mem_rdata),
    .i_prog_addr(i_prog_addr), .o_prog_addr_ok(o_prog_addr_ok), .i_port_zero_pin(p_pin[0]),
    .i_port_one_pin(p_pin[1]), .i_port_two_pin(p_pin[2]), .i_port_three_pin(p_pin[3]), .i_port_four_pin(p_pin[4]),
    .o_port_zero_out(p_out[0]), .o_port_zero_oe(p_oe[0]), .o_port_one_out(p_out[1]), .o_port_one_oe(p_oe[1]),
    .o_port_two_out(p_out[2]), .o_port_two_oe(p_oe[2]), .o_port_three_out(p_out[3]), .o_port_three_oe(p_oe[3]),
    .o_port_four_out(p_out[4]), .o_port_four_oe(p_oe[4]), .o_data_pointer(o_data_pointer),
    .o_stack_ptr(o_stack_ptr), .o_ir_output_control(o_ir_output_control), .o_selfprog_control(o_selfprog_control),
    .o_clock_setup(o_clock_setup), .o_pin_setup(o_pin_setup), .o_undervoltage_setup(o_undervoltage_setup),
    .o_function_flags(o_function_flags), .o_stop_wake(o_stop_wake));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick;
    @(posedge i_mclk);
    #1;
  endtask : tick
  // One commit per call, with an idle edge before it, so no two requests share an edge.
  // The bench plays a full-pin part, so no write ever lands on a register that a reduced part lacks.
  task automatic op(input logic [3:0] adr, input logic [3:0] wd, input logic wr, input logic fs, input logic fc);
    tick();
    {i_reg_addr, i_reg_wdata, i_reg_wr, i_flag_set, i_flag_clr, i_final_cycle_state} = {adr, wd, wr, fs, fc, 1'b1};
    tick();
    {i_reg_wr, i_flag_set, i_flag_clr, i_final_cycle_state} = 4'h0;
  endtask : op
  task automatic do_reset(input logic por);
    tick();
    {i_rst, i_por} = {1'b1, por};
    tick();
    tick();
    {i_rst, i_por} = 2'b00;
  endtask : do_reset
  task automatic check_reset(input logic por, input logic [11:0] cfg);
    for (int a = 0; a < 13; a++) begin
      i_reg_addr = 4'(a);
      #1;
      check(o_reg_rdata, rst_rd[a], "reset read");
    end
    check({o_function_flags, o_ir_output_control}, 20'h23FF0, "reset flags");
    check({p_oe[0], p_oe[1], p_oe[2], p_oe[3], p_oe[4]}, 20'h0, "reset enables");
    check({o_clock_setup, o_pin_setup, o_undervoltage_setup & 4'hB}, por ? 12'h008 : cfg, "setup");
  endtask : check_reset
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  initial begin
    {i_rst, i_por, i_final_cycle_state, i_reg_wr, i_flag_set, i_flag_clr} = 6'h30;
    {i_mem_wr, i_mem_bit_set, i_mem_bit_clr, i_mem_bit_sel, i_mem_addr, i_mem_wdata} = 15'h0;
    {i_reg_addr, i_reg_wdata, i_prog_addr} = 18'h0;
    p_pin = '{4'hF, 4'hF, 4'h5, 4'h9, 4'h3};
    tick();
    tick();
    {i_rst, i_por} = 2'b00;
    check_reset(1'b1, 12'h0);
    foreach (rows[k]) begin
      op(rows[k].adr, rows[k].wd, 1'b1, 1'b0, 1'b0);
      check(o_reg_rdata, rows[k].rd, "row read");
    end
    check({o_data_pointer, o_stack_ptr, o_ir_output_control}, 16'hD6A9, "pointers");
    check({p_oe[0], p_oe[3], p_oe[4], p_oe[2], p_out[2]}, 20'hD5BF6, "port drive");
    check({p_out[0], p_out[1], p_out[3], p_out[4]}, 16'h0, "open drain out");
    tick();
    {i_reg_addr, i_reg_wdata, i_reg_wr} = 9'h15F;
    tick();
    i_reg_wr = 1'b0;
    check(o_reg_rdata, 4'h6, "uncommitted write");
    op(4'h2, 4'h5, 1'b1, 1'b0, 1'b0);
    op(4'h2, 4'h0, 1'b0, 1'b0, 1'b1);
    check({o_function_flags[5], p_oe[3]}, 5'h07, "flag clear");
    op(4'h2, 4'h0, 1'b0, 1'b1, 1'b1);
    check(p_oe[3], 4'h7, "set with clear");
    op(4'h2, 4'h0, 1'b0, 1'b1, 1'b0);
    check({o_function_flags[5], p_oe[3]}, 5'h15, "flag set");
    op(4'h2, 4'hB, 1'b1, 1'b0, 1'b0);
    op(4'h9, 4'h0, 1'b0, 1'b1, 1'b0);
    op(4'h9, 4'h3, 1'b1, 1'b0, 1'b0);
    check({o_reg_rdata, o_selfprog_control}, 8'h33, "selfprog open");
    op(4'h2, 4'hA, 1'b1, 1'b0, 1'b0);
    op(4'h9, 4'h0, 1'b0, 1'b1, 1'b0);
    op(4'h9, 4'hC, 1'b1, 1'b0, 1'b0);
    check({o_reg_rdata, o_selfprog_control}, 8'h03, "selfprog shut");
    op(4'h2, 4'hF, 1'b1, 1'b0, 1'b0);
    op(4'h4, 4'h0, 1'b0, 1'b1, 1'b0);
    check({o_function_flags[15], o_stop_wake}, 2'h2, "stop");
    p_pin[1] = 4'hB;
    tick();
    check({o_function_flags[15], o_stop_wake, o_reg_rdata}, 6'h1B, "wake");
    p_pin[1] = 4'hF;
    {i_mem_addr, i_mem_wdata, i_mem_wr, i_final_cycle_state, i_prog_addr} = {6'h3F, 4'hA, 2'b11, 10'h3FF};
    tick();
    {i_mem_wr, i_mem_bit_set} = 2'b01;
    tick();
    {i_mem_bit_set, i_mem_bit_clr, i_mem_bit_sel} = 4'h7;
    tick();
    {i_mem_bit_clr, i_final_cycle_state} = 2'b00;
    tick();
    check({o_mem_rdata, o_prog_addr_ok}, 5'h07, "memory");
    do_reset(1'b0);
    check_reset(1'b0, 12'h78B);
    do_reset(1'b1);
    check_reset(1'b1, 12'h0);
    stop_test();
  end
endmodule : testbench
bind nsf_register_file nsf_reg_chk nsf_reg_chk_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_por(i_por),
  .i_final_cycle_state(i_final_cycle_state), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_wdata(i_reg_wdata), .i_flag_set(i_flag_set), .i_flag_clr(i_flag_clr), .i_port_zero_pin(i_port_zero_pin),
  .i_port_one_pin(i_port_one_pin), .o_reg_rdata(o_reg_rdata), .o_port_two_oe(o_port_two_oe),
  .o_data_pointer(o_data_pointer), .o_stack_ptr(o_stack_ptr), .o_selfprog_control(o_selfprog_control),
  .o_clock_setup(o_clock_setup), .o_pin_setup(o_pin_setup), .o_undervoltage_setup(o_undervoltage_setup),
  .o_function_flags(o_function_flags), .o_stop_wake(o_stop_wake));
`default_nettype wire
